// *** design/pbm_basic_pcs.sv ***
// Basic-mode PCS: rate match, low-latency bypass, idle, signal detect, auto commas
// How it works
// R1 - A skip cluster loses at most four skips and always keeps at least one.
// R2 - A skip cluster shorter than five skips gets at most four extra skips.
// R3 - A byte arriving at a full FIFO is dropped and the full flag rides on the next byte out.
// R4 - When the FIFO runs empty, K30.7 (9'h1FE) is sent after the last byte with the empty flag on it.
// R5 - Low-latency mode passes data straight around coding, alignment, rate match and ordering.
// R6 - Electrical idle turns the differential driver off.
// R7 - Signal detect is only reported while 8b/10b coding is enabled.
// R8 - In gigabit Ethernet mode three K28.5 commas go out after transmit reset, before user data.
// R9 - The far receiver loses sync if an even count of data groups precedes its first comma.
// R10 - The controlling logic holds the PLL reset for at least one microsecond after power-up.
// R11 - Transmit and receive resets stay asserted while the PLL reset is applied.
// R12 - Transmit reset is released only after PLL lock.
// R13 - Full and empty flags last one word cycle per affected byte and never latch.
// R14 - User logic sends an odd number of data groups before its first sync comma.
`timescale 1ns/100ps
module pbm_basic_pcs #(
  parameter int FIFO_DEPTH = pbm_pkg::FIFO_DEPTH
) (
  input  wire logic                core_clk,
  input  wire logic                srst,
  input  wire logic                low_latency,
  input  wire logic                coding_enable,
  input  wire logic                gigabit_ethernet_mode,
  input  wire logic                elec_idle,
  input  wire logic                sig_present_pin,
  input  wire pbm_pkg::pbm_sym_type rx_in,
  input  wire logic                rx_in_valid,
  input  wire logic [9:0]          rx_raw,
  output pbm_pkg::pbm_sym_type     rx_out_q,
  output logic [9:0]               rx_raw_out_q,
  output pbm_pkg::pbm_flag_type    rx_flags_q,
  output logic                     sig_detect_q,
  input  wire pbm_pkg::pbm_sym_type tx_in,
  output logic                     tx_in_ready_q,
  output pbm_pkg::pbm_sym_type     tx_out_q,
  output logic [9:0]               tx_raw_out_q,
  input  wire logic [9:0]          tx_raw,
  output logic                     tx_drv_oe_q
);
  localparam int AW = $clog2(FIFO_DEPTH);
  if (FIFO_DEPTH <= pbm_pkg::FIFO_HI_MARK) begin : g_depth_check
    $error("FIFO_DEPTH too small for rate match marks");
  end

  // Receive rate match
  logic [2:0]  ins_cnt_q;
  logic [2:0]  del_cnt_q;
  logic [3:0]  clus_in_q;
  logic [3:0]  clus_out_q;
  logic        drop_pend_q;
  logic        was_empty_q;
  logic        in_ready;
  logic        f_valid;
  logic [8:0]  f_data;
  logic [AW:0] level;
  pbm_pkg::pbm_sym_type f_sym;
  assign f_sym = pbm_pkg::pbm_sym_type'(f_data);

  wire in_skip   = {rx_in.ctrl, rx_in.data} == pbm_pkg::SKIP_SYM;
  wire out_skip  = f_valid && f_data == pbm_pkg::SKIP_SYM;
  wire fifo_high = level >= (AW+1)'(pbm_pkg::FIFO_HI_MARK);
  wire fifo_low  = level <= (AW+1)'(pbm_pkg::FIFO_LO_MARK);
  // Delete only a skip that follows another skip, so one always survives
  wire del_skip  = rx_in_valid && in_skip && clus_in_q != 4'h0 && fifo_high
                   && del_cnt_q < 3'(pbm_pkg::MAX_DEL); // R1
  // Repeat the skip at the FIFO head while its cluster is short and the FIFO runs low
  // Bypass freezes the FIFO, so no skip may be repeated then
  wire ins_skip  = !low_latency && out_skip && fifo_low && clus_out_q < 4'(pbm_pkg::MIN_CLUSTER)
                   && ins_cnt_q < 3'(pbm_pkg::MAX_INS); // R2
  wire rx_drop   = rx_in_valid && !in_ready; // R3
  wire wr_valid  = rx_in_valid && !del_skip && !low_latency;
  wire rd_ready  = !ins_skip && !low_latency;

  pbm_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (core_clk),
    .srst      (srst),
    .in_data   ({rx_in.ctrl, rx_in.data}),
    .in_valid  (wr_valid),
    .in_ready  (in_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (rd_ready),
    .level     (level)
  );

  always_ff @(posedge core_clk) begin
    if (srst) begin
      clus_in_q  <= 4'h0;
      del_cnt_q  <= 3'h0;
      clus_out_q <= 4'h0;
      ins_cnt_q  <= 3'h0;
    end else begin
      if (rx_in_valid) begin
        clus_in_q <= in_skip ? (clus_in_q == 4'hF ? clus_in_q : clus_in_q + 4'h1) : 4'h0;
        del_cnt_q <= !in_skip ? 3'h0 : del_skip ? del_cnt_q + 3'h1 : del_cnt_q; // R1
      end
      if (f_valid) begin
        clus_out_q <= out_skip ? (clus_out_q == 4'hF ? clus_out_q : clus_out_q + 4'h1) : 4'h0;
        ins_cnt_q  <= !out_skip ? 3'h0 : ins_skip ? ins_cnt_q + 3'h1 : ins_cnt_q; // R2
      end
    end
  end

  // Output side: flag per affected byte, one cycle each
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rx_out_q     <= '0;
      rx_raw_out_q <= 10'h000;
      rx_flags_q   <= '0;
      drop_pend_q  <= 1'b0;
      was_empty_q  <= 1'b0;
    end else if (low_latency) begin
      rx_raw_out_q <= rx_raw; // R5
      rx_out_q     <= '0;
      rx_flags_q   <= '0;
      drop_pend_q  <= 1'b0;
      was_empty_q  <= 1'b0;
    end else begin
      rx_raw_out_q <= 10'h000;
      drop_pend_q  <= rx_drop || (drop_pend_q && !f_valid);
      if (f_valid) begin
        rx_out_q         <= f_sym;
        rx_flags_q.full  <= drop_pend_q; // R3 R13
        rx_flags_q.empty <= 1'b0; // R13
        was_empty_q      <= 1'b0;
      end else begin
        // Fill K30.7 on every cycle the FIFO stays empty after the byte that drained it
        rx_out_q         <= pbm_pkg::pbm_sym_type'(pbm_pkg::K30_7_SYM); // R4
        rx_flags_q.empty <= 1'b1; // R4 R13
        rx_flags_q.full  <= 1'b0;
        was_empty_q      <= 1'b1;
      end
    end
  end

  // Signal detect: pin synchronised, gated by coding enable
  logic sd_meta_q;
  logic sd_sync_q;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sd_meta_q    <= 1'b0;
      sd_sync_q    <= 1'b0;
      sig_detect_q <= 1'b0;
    end else begin
      sd_meta_q    <= sig_present_pin;
      sd_sync_q    <= sd_meta_q;
      sig_detect_q <= sd_sync_q && coding_enable && !low_latency; // R7
    end
  end

  // Transmit: automatic commas, bypass and electrical idle
  logic [1:0] comma_cnt_q;
  wire        comma_phase = gigabit_ethernet_mode && !low_latency && comma_cnt_q != 2'(pbm_pkg::AUTO_COMMAS);
  always_ff @(posedge core_clk) begin
    if (srst) begin
      comma_cnt_q   <= 2'h0;
      tx_out_q      <= '0;
      tx_raw_out_q  <= 10'h000;
      tx_in_ready_q <= 1'b0;
      tx_drv_oe_q   <= 1'b0;
    end else begin
      tx_drv_oe_q   <= !elec_idle; // R6
      tx_raw_out_q  <= low_latency ? tx_raw : 10'h000; // R5
      if (comma_phase) begin
        comma_cnt_q <= comma_cnt_q + 2'h1; // R8
        tx_out_q    <= pbm_pkg::pbm_sym_type'(pbm_pkg::K28_5_SYM); // R8
      end else begin
        tx_out_q    <= low_latency ? '0 : tx_in;
      end
      // User data is taken only once the comma burst is over
      tx_in_ready_q <= !(gigabit_ethernet_mode && !low_latency
                         && comma_cnt_q < 2'(pbm_pkg::AUTO_COMMAS - 1)); // R8
    end
  end

  // Assertions
  property p_empty_fill;
    @(posedge core_clk) disable iff (srst)
      (!low_latency && !f_valid) |=> rx_flags_q.empty && {rx_out_q.ctrl, rx_out_q.data} == pbm_pkg::K30_7_SYM;
  endproperty
  a_empty_fill: assert property (p_empty_fill) else $error("empty fill missing"); // R4
  property p_full_flag;
    @(posedge core_clk) disable iff (srst)
      rx_flags_q.full |-> $past(drop_pend_q) && !rx_flags_q.empty;
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flag without drop"); // R3
  property p_flag_pulse;
    @(posedge core_clk) disable iff (srst)
      (!low_latency && f_valid && !drop_pend_q) |=> !rx_flags_q.full && !rx_flags_q.empty;
  endproperty
  a_flag_pulse: assert property (p_flag_pulse) else $error("full flag latched"); // R13
  property p_del_limit;
    @(posedge core_clk) disable iff (srst) del_skip |-> clus_in_q != 4'h0 && del_cnt_q < 3'h4;
  endproperty
  a_del_limit: assert property (p_del_limit) else $error("skip deletion limit broken"); // R1
  property p_ins_limit;
    @(posedge core_clk) disable iff (srst)
      ins_skip |-> (ins_cnt_q < 3'h4 && clus_out_q < 4'h5)
                   ##1 ({rx_out_q.ctrl, rx_out_q.data} == pbm_pkg::SKIP_SYM);
  endproperty
  a_ins_limit: assert property (p_ins_limit) else $error("skip insertion limit broken"); // R2
  property p_bypass;
    @(posedge core_clk) disable iff (srst) low_latency |=> rx_raw_out_q == $past(rx_raw) && !rx_flags_q.empty;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass path wrong"); // R5
  property p_idle;
    @(posedge core_clk) disable iff (srst) elec_idle |=> !tx_drv_oe_q;
  endproperty
  a_idle: assert property (p_idle) else $error("driver on in idle"); // R6
  property p_sigdet;
    @(posedge core_clk) disable iff (srst) !coding_enable |=> !sig_detect_q;
  endproperty
  a_sigdet: assert property (p_sigdet) else $error("signal detect without coding"); // R7
  sequence s_commas;
    ({tx_out_q.ctrl, tx_out_q.data} == pbm_pkg::K28_5_SYM) [*3];
  endsequence
  property p_commas;
    @(posedge core_clk) disable iff (srst)
      ($fell(srst) && gigabit_ethernet_mode && !low_latency) |=> s_commas;
  endproperty
  a_commas: assert property (p_commas) else $error("auto commas missing"); // R8
endmodule : pbm_basic_pcs

// *** design/pbm_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module pbm_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
    $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  assign level     = wr_q - rd_q;
  assign in_ready  = level != DEPTH[AW:0];
  assign out_valid = level != '0;
  assign out_data  = mem_q[rd_q[AW-1:0]];
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (push) mem_q[wr_q[AW-1:0]] <= in_data;
  end
endmodule : pbm_fifo

// *** design/pbm_pkg.sv ***
// Package for the basic-mode rate-match and transmit coding block
package pbm_pkg;
  localparam logic [8:0] SKIP_SYM       = 9'h1BC;
  localparam logic [8:0] K30_7_SYM      = 9'h1FE;
  localparam logic [8:0] K28_5_SYM      = 9'h1BC;
  localparam int         MAX_DEL        = 4;
  localparam int         MAX_INS        = 4;
  localparam int         MIN_CLUSTER    = 5;
  localparam int         AUTO_COMMAS    = 3;
  localparam int         FIFO_DEPTH     = 16;
  localparam int         FIFO_LO_MARK   = 4;
  localparam int         FIFO_HI_MARK   = 12;

  typedef struct packed {
    logic       ctrl;
    logic [7:0] data;
  } pbm_sym_type;

  typedef struct packed {
    logic full;
    logic empty;
  } pbm_flag_type;
endpackage : pbm_pkg

// *** verif/pbm_basic_pcs_tb_top.sv ***
// Self-checking bench for the basic-mode PCS block
`timescale 1ns/100ps
module pbm_basic_pcs_tb_top;
  logic                 core_clk = 1'b0;
  logic                 srst = 1'b1;
  logic                 low_latency = 1'b0;
  logic                 coding_enable = 1'b0;
  logic                 gigabit_ethernet_mode = 1'b0;
  logic                 elec_idle = 1'b0;
  logic                 sig_present_pin = 1'b0;
  logic [9:0]           rx_raw = 10'h000;
  logic [9:0]           tx_raw = 10'h000;
  pbm_pkg::pbm_sym_type tx_in = '0;
  pbm_pkg::pbm_sym_type rx_in;
  pbm_pkg::pbm_sym_type rx_out_q;
  pbm_pkg::pbm_sym_type tx_out_q;
  pbm_pkg::pbm_flag_type rx_flags_q;
  logic                 rx_in_valid;
  logic [9:0]           rx_raw_out_q;
  logic [9:0]           tx_raw_out_q;
  logic                 sig_detect_q;
  logic                 tx_drv_oe_q;
  logic                 tx_in_ready_q;
  int                   fail_count = 0;
  int                   samples_checked = 0;

  always #10 core_clk = ~core_clk;

  pbm_link_partner pbm_link_partner_inst (.core_clk(core_clk), .rx_in(rx_in), .rx_in_valid(rx_in_valid));

  pbm_basic_pcs pbm_basic_pcs_inst (
    .core_clk(core_clk), .srst(srst), .low_latency(low_latency), .coding_enable(coding_enable),
    .gigabit_ethernet_mode(gigabit_ethernet_mode), .elec_idle(elec_idle), .sig_present_pin(sig_present_pin),
    .rx_in(rx_in), .rx_in_valid(rx_in_valid), .rx_raw(rx_raw), .rx_out_q(rx_out_q),
    .rx_raw_out_q(rx_raw_out_q), .rx_flags_q(rx_flags_q), .sig_detect_q(sig_detect_q), .tx_in(tx_in),
    .tx_in_ready_q(tx_in_ready_q), .tx_out_q(tx_out_q), .tx_raw_out_q(tx_raw_out_q), .tx_raw(tx_raw),
    .tx_drv_oe_q(tx_drv_oe_q)
  );

  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  // Long hold stands in for the PLL reset window of the channel sequence
  task automatic do_reset(input logic gbe);
    @(negedge core_clk);
    srst = 1'b1;
    gigabit_ethernet_mode = gbe;
    repeat (12) @(negedge core_clk);
    srst = 1'b0;
  endtask : do_reset

  task automatic test_auto_commas;
    int n;
    n = 0;
    tx_in = 9'h055;
    do_reset(1'b1);
    check(tx_out_q, 10'h000);
    check(tx_in_ready_q, 10'h000);
    repeat (3) begin
      @(negedge core_clk);
      if (tx_out_q === pbm_pkg::K28_5_SYM) n++;
    end
    check(n[9:0], 10'(pbm_pkg::AUTO_COMMAS));
    check(tx_in_ready_q, 10'h001);
    @(negedge core_clk);
    check(tx_out_q, 10'h055);
    // One data group, an odd count, before the sync comma keeps the far end in step
    tx_in = pbm_pkg::K28_5_SYM;
    @(negedge core_clk);
    check(tx_out_q, pbm_pkg::K28_5_SYM);
  endtask : test_auto_commas

  task automatic test_rx_stream;
    int k;
    k = 0;
    do_reset(1'b0);
    repeat (4) @(negedge core_clk);
    check(rx_out_q, pbm_pkg::K30_7_SYM);
    check(rx_flags_q, 10'h001);
    pbm_link_partner_inst.send(9'h03A, 0);
    while (rx_out_q !== 9'h03A && k < 10) begin
      @(negedge core_clk);
      k++;
    end
    check(rx_out_q, 10'h03A);
    check(rx_flags_q, 10'h000);
    @(negedge core_clk);
    check(rx_out_q, pbm_pkg::K30_7_SYM);
    check(rx_flags_q, 10'h001);
  endtask : test_rx_stream

  // A lone skip with the FIFO running low grows to a full cluster
  task automatic test_skip_insert;
    int n;
    n = 0;
    pbm_link_partner_inst.send(pbm_pkg::SKIP_SYM, 0);
    repeat (12) begin
      @(negedge core_clk);
      if (rx_out_q === pbm_pkg::SKIP_SYM) n++;
    end
    check(n[9:0], 10'(1 + pbm_pkg::MAX_INS));
    check(rx_out_q, pbm_pkg::K30_7_SYM);
    check(rx_flags_q, 10'h001);
  endtask : test_skip_insert

  task automatic test_bypass;
    low_latency = 1'b1;
    rx_raw = 10'h2AA;
    tx_raw = 10'h155;
    repeat (3) @(negedge core_clk);
    check(rx_raw_out_q, 10'h2AA);
    check(tx_raw_out_q, 10'h155);
    rx_raw = 10'h0F3;
    @(negedge core_clk);
    check(rx_raw_out_q, 10'h0F3);
    low_latency = 1'b0;
    repeat (2) @(negedge core_clk);
    check(rx_raw_out_q, 10'h000);
  endtask : test_bypass

  task automatic test_idle_detect;
    repeat (2) @(negedge core_clk);
    check(tx_drv_oe_q, 10'h001);
    elec_idle = 1'b1;
    repeat (2) @(negedge core_clk);
    check(tx_drv_oe_q, 10'h000);
    elec_idle = 1'b0;
    sig_present_pin = 1'b1;
    repeat (4) @(negedge core_clk);
    check(sig_detect_q, 10'h000);
    coding_enable = 1'b1;
    repeat (4) @(negedge core_clk);
    check(sig_detect_q, 10'h001);
  endtask : test_idle_detect

  initial begin
    test_auto_commas();
    test_rx_stream();
    test_skip_insert();
    test_bypass();
    test_idle_detect();
    close_out();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #(2000 * 20);
    fail_count++;
    close_out();
  end
endmodule : pbm_basic_pcs_tb_top

// *** verif/pbm_link_partner.sv ***
// Remote link partner model that feeds the receive symbol stream
`timescale 1ns/100ps
module pbm_link_partner (
  input  wire logic            core_clk,
  output pbm_pkg::pbm_sym_type rx_in,
  output logic                 rx_in_valid
);
  initial begin
    rx_in       = '0;
    rx_in_valid = 1'b0;
  end

  // Line flips after each symbol so a stale value cannot pass for a fresh one
  task automatic send(input logic [8:0] sym, input int gap);
    @(negedge core_clk);
    rx_in       = sym;
    rx_in_valid = 1'b1;
    @(negedge core_clk);
    rx_in_valid = 1'b0;
    rx_in       = ~sym;
    repeat (gap) @(negedge core_clk);
  endtask : send
endmodule : pbm_link_partner
